// ---- process_regulator.sv ----
// process_regulator.sv: PID regulator with emergency run override
// assumes trip/alarm and limit inputs are synchronous; di pins are asynchronous
// Function
// - integrator ramps proportional to error
// - integral time equals time to match P
// - derivative zero on constant error
// - derivative time zero disables derivative
// - derivative gain clamped at configured limit
// - feedback first-order low-pass, tau configurable
// - PID settings act only in closed loop
// - selector decodes off, fwd, rev, bypass
// - selector zero keeps emergency inactive
// - emergency suppresses trip lock, and trips except in bypass mode
// - emergency output is fixed reference frequency
// - either of two inputs starts emergency
// - bypass mode trips after programmed delay
// - output raised after trip and delay
// - proportional gain times deviation
// - polarity selects sign of deviation
// - anti-windup tracks output at limits
`default_nettype none
module process_regulator
  import regulator_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int TICKS_PER_S = SAMPLE_HZ
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic closedLoop,
  input wire logic signed [DW-1:0] setpoint,
  input wire logic signed [DW-1:0] feedback,
  input wire logic [15:0] proportional_gain_setting,
  input wire logic [19:0] integral_time_setting,
  input wire logic [15:0] derivative_time_setting,
  input wire logic [15:0] derivGainLimit,
  input wire logic [15:0] feedback_filter_tau,
  input wire logic regulator_polarity,
  input wire logic integrator_clamp_enable,
  input wire logic limitReached,
  input wire logic signed [DW-1:0] actualFreq,
  input wire logic [1:0] emergencyMode,
  input wire logic [15:0] emergency_run_frequency,
  input wire logic [15:0] emergency_trip_delay,
  input wire logic emergPinA,
  input wire logic emergPinB,
  input wire logic alarm,
  output logic signed [DW-1:0] freqCmd,
  output logic reverseDir,
  output logic emergActive,
  output logic tripOut,
  output logic tripSuppress,
  output logic bypassOut
);
  // ----------------------------------------------------------------
  // sample tick divider
  // ----------------------------------------------------------------
  logic [31:0] divCnt_r;
  logic tick;
  assign tick = (divCnt_r == 32'(SAMPLE_CYCLES - 1));
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      divCnt_r <= 32'h0000_0000;
    else
      divCnt_r <= tick ? 32'h0000_0000 : divCnt_r + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pinMeta_r;
  logic [1:0] pinSync_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinMeta_r <= 2'h0;
      pinSync_r <= 2'h0;
    end
    else
    begin
      pinMeta_r <= {emergPinB, emergPinA};
      pinSync_r <= pinMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // feedback filter and deviation
  // ----------------------------------------------------------------
  logic signed [DW-1:0] fbFilt;
  lowpass_filter lowpass_filter_i (
    .clk(clk),
    .resetn(resetn),
    .tick(tick),
    .tauCs(feedback_filter_tau),
    .din(feedback),
    .dout(fbFilt)
  );
  wire signed [DW-1:0] devRaw = setpoint - fbFilt;
  wire signed [DW-1:0] dev = regulator_polarity ? -devRaw : devRaw;

  // ----------------------------------------------------------------
  // PID terms, gains in hundredths
  // ----------------------------------------------------------------
  logic signed [DW-1:0] integ_r;
  logic signed [DW-1:0] devPrev_r;
  logic signed [DW-1:0] dTerm_r;
  logic holdI_r;
  wire signed [47:0] pFull = 48'(dev) * $signed({32'h0000_0000, proportional_gain_setting});
  wire signed [DW-1:0] pTerm = DW'(pFull / 48'sd100);
  // I per tick = P / (Ti * ticks); Ti in hundredths of a second
  wire signed [63:0] iDen = $signed({44'h0, integral_time_setting}) * 64'(TICKS_PER_S);
  wire signed [63:0] iStep = (iDen == 64'sd0) ? 64'sd0 : 64'(pFull) / iDen;
  wire signed [DW-1:0] dDev = dev - devPrev_r;
  // derivative: Kp*Td*dDev/Ts, clamped to limit*P-gain*dDev
  wire signed [63:0] dRaw = 64'(dDev) *
    $signed({48'h0, proportional_gain_setting}) * $signed({48'h0, derivative_time_setting})
    * 64'(TICKS_PER_S) / 64'sd10000;
  wire signed [63:0] dLim = 64'(dDev) * $signed({48'h0, proportional_gain_setting})
    * $signed({48'h0, derivGainLimit}) / 64'sd10000;
  wire dOver = (dLim >= 0) ? (dRaw > dLim) : (dRaw < dLim);
  wire signed [DW-1:0] dSel = (derivative_time_setting == 16'h0000) ? ZERO_W :
    (dOver ? DW'(dLim) : DW'(dRaw));
  wire signChange = (dev[DW-1] != devPrev_r[DW-1]) || (dev == ZERO_W);
  wire holdNxt = integrator_clamp_enable && (limitReached || (holdI_r && !signChange));
  wire pidRun = closedLoop && !emergActive;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      integ_r <= ZERO_W;
      devPrev_r <= ZERO_W;
      dTerm_r <= ZERO_W;
      holdI_r <= 1'b0;
    end
    else if (tick && pidRun)
    begin
      holdI_r <= holdNxt;
      integ_r <= holdNxt ? actualFreq - pTerm - dSel : integ_r + DW'(iStep);
      devPrev_r <= dev;
      dTerm_r <= dSel;
    end
  end

  // ----------------------------------------------------------------
  // emergency run and bypass trip timer
  // ----------------------------------------------------------------
  wire emergReq = (emergencyMode != MODE_OFF) && (pinSync_r != 2'h0);
  trip_e trip_r;
  logic [31:0] secCnt_r;
  logic [15:0] delayCnt_r;
  wire secTick = tick && (secCnt_r == 32'(TICKS_PER_S - 1));
  wire bypassMode = emergActive && (emergencyMode == MODE_BYP);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trip_r <= ST_IDLE;
      secCnt_r <= 32'h0000_0000;
      delayCnt_r <= 16'h0000;
    end
    else if (!bypassMode)
      trip_r <= ST_IDLE;
    else
    begin
      if (tick)
        secCnt_r <= secTick ? 32'h0000_0000 : secCnt_r + 32'h0000_0001;
      case (trip_r)
        ST_IDLE:
          if (alarm)
          begin
            trip_r <= ST_WAIT;
            delayCnt_r <= 16'h0000;
            secCnt_r <= 32'h0000_0000;
          end
        ST_WAIT:
          if (delayCnt_r >= emergency_trip_delay || delayCnt_r >= TRIP_DELAY_MAX_S)
            trip_r <= ST_TRIP;
          else if (secTick)
            delayCnt_r <= delayCnt_r + 16'h0001;
        default:
          trip_r <= ST_TRIP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire signed [DW-1:0] sumCmd = pTerm + integ_r + dTerm_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      emergActive <= 1'b0;
      freqCmd <= ZERO_W;
      reverseDir <= 1'b0;
      tripOut <= 1'b0;
      tripSuppress <= 1'b0;
      bypassOut <= 1'b0;
    end
    else
    begin
      emergActive <= emergReq;
      tripSuppress <= emergReq;
      tripOut <= emergActive ? (trip_r == ST_TRIP) : alarm;
      bypassOut <= (trip_r == ST_TRIP);
      if (emergActive)
      begin
        freqCmd <= DW'({8'h00, emergency_run_frequency});
        reverseDir <= (emergencyMode == MODE_REV);
      end
      else if (tick && closedLoop)
      begin
        freqCmd <= sumCmd;
        reverseDir <= 1'b0;
      end
    end
  end

  AST_EMERG_FREQ: assert property (@(posedge clk) disable iff (!resetn)
    emergActive |=> freqCmd == DW'({8'h00, $past(emergency_run_frequency)}))
    else $error("emergency frequency not applied");
  AST_OFF_INACTIVE: assert property (@(posedge clk) disable iff (!resetn)
    emergencyMode == MODE_OFF |=> !emergActive)
    else $error("emergency active while disabled");
  AST_SUPPRESS: assert property (@(posedge clk) disable iff (!resetn)
    emergActive |-> tripSuppress)
    else $error("trip not suppressed");
  AST_NO_TRIP_EMERG: assert property (@(posedge clk) disable iff (!resetn)
    emergActive && trip_r != ST_TRIP |=> !tripOut)
    else $error("trip raised during emergency run");
  AST_REV: assert property (@(posedge clk) disable iff (!resetn)
    emergActive && emergencyMode == MODE_REV |=> reverseDir)
    else $error("reverse not selected");
  AST_BYP_OUT: assert property (@(posedge clk) disable iff (!resetn)
    bypassOut |-> $past(trip_r == ST_TRIP))
    else $error("bypass output without trip");
  AST_NO_EARLY_TRIP: assert property (@(posedge clk) disable iff (!resetn)
    trip_r == ST_TRIP && $past(trip_r) == ST_WAIT |->
    $past(delayCnt_r) >= emergency_trip_delay || $past(delayCnt_r) >= TRIP_DELAY_MAX_S)
    else $error("trip before delay");
  AST_D_OFF: assert property (@(posedge clk) disable iff (!resetn)
    tick && pidRun && derivative_time_setting == 16'h0000 |=> dTerm_r == ZERO_W)
    else $error("derivative not off");
  AST_D_CONST: assert property (@(posedge clk) disable iff (!resetn)
    tick && pidRun && dev == devPrev_r |=> dTerm_r == ZERO_W)
    else $error("derivative moved on constant error");
  AST_HOLD_PID: assert property (@(posedge clk) disable iff (!resetn)
    !closedLoop && !emergActive |=> $stable(integ_r))
    else $error("integrator moved in open loop");
  COV_EMERG: cover property (@(posedge clk) emergActive);
  COV_REV: cover property (@(posedge clk) emergActive && reverseDir);
  COV_TRIP: cover property (@(posedge clk) bypassOut);
  COV_PID: cover property (@(posedge clk) tick && pidRun);
endmodule : process_regulator
`default_nettype wire

// ---- regulator_pkg.sv ----
// regulator_pkg.sv: constants for the process regulator and emergency run
// assumes a 200 MHz clock and a fixed regulator sample period
`default_nettype none
package regulator_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_US = 1000;
  localparam int SAMPLE_CYC = CLK_MHZ * SAMPLE_US;
  localparam int SAMPLE_HZ = 1000;
  localparam int DW = 24;
  localparam int FRAC = 8;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_FWD = 2'h1;
  localparam logic [1:0] MODE_REV = 2'h2;
  localparam logic [1:0] MODE_BYP = 2'h3;
  localparam logic [15:0] EMERG_FREQ_RST = 16'h01F4;
  localparam logic [15:0] FILTER_TAU_RST = 16'h0001;
  localparam logic [15:0] PGAIN_RST = 16'h0001;
  localparam logic [15:0] TRIP_DELAY_MAX_S = 16'h0258;
  localparam logic [DW-1:0] ZERO_W = 24'h00_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_TRIP = 3'b100
  } trip_e;
endpackage : regulator_pkg
`default_nettype wire

// ---- lowpass_filter.sv ----
// lowpass_filter.sv: first-order feedback filter, one step per sample tick
// assumes tau is given in hundredths of a second
`default_nettype none
module lowpass_filter
  import regulator_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic [15:0] tauCs,
  input wire logic signed [DW-1:0] din,
  output logic signed [DW-1:0] dout
);
  // y += (x - y) * Ts / tau with Ts = 1 ms and tau in centiseconds
  logic signed [DW+15:0] diffW;
  logic signed [DW+15:0] stepW;
  assign diffW = (DW+16)'(din - dout) * 40'sd10;
  assign stepW = diffW / $signed({24'h00_0000, (tauCs == 16'h0000) ? 16'h0001 : tauCs}) / 40'sd100;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dout <= ZERO_W;
    else if (tick)
      dout <= dout + DW'(stepW);
  end
endmodule : lowpass_filter
`default_nettype wire

// ---- drive_stage_model.sv ----
// drive_stage_model.sv: behavioural output stage driven by the frequency command
// assumes the regulator clock and reset
`default_nettype none
module drive_stage_model
  import regulator_pkg::*;
#(
  parameter logic signed [DW-1:0] LIMIT = 24'h00_4000
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic signed [DW-1:0] freqCmd,
  output logic signed [DW-1:0] actualFreq,
  output logic limitReached
);
  // ----
  // motor follows the command but saturates at the limit
  // ----
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      actualFreq <= ZERO_W;
    else
      actualFreq <= (freqCmd > LIMIT) ? LIMIT : freqCmd;
  end
  assign limitReached = (freqCmd >= LIMIT);
endmodule : drive_stage_model
`default_nettype wire

// ---- test_process_regulator.sv ----
// test_process_regulator.sv: self-checking bench for the regulator
// assumes regulator_pkg and drive_stage_model are compiled first
`default_nettype none
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_process_regulator import regulator_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10;
  logic clk = 1'b0, resetn = 1'b0, closedLoop = 1'b0, pol = 1'b0, clampEn = 1'b1;
  logic pinA = 1'b0, pinB = 1'b0, alarm = 1'b0;
  logic signed [DW-1:0] setpoint = 24'h00_0100, fb = ZERO_W, actualFreq, freqCmd;
  logic [15:0] pGain = 16'h0064, dTime = 16'h0000, dLim = 16'h0064, tau = FILTER_TAU_RST;
  logic [15:0] eFreq = EMERG_FREQ_RST, eDelay = 16'h0001;
  logic [19:0] iTime = 20'h0_0064;
  logic [1:0] mode = MODE_OFF;
  logic limitReached, reverseDir, emergActive, tripOut, tripSuppress, bypassOut;
  int errors = 0, nChecks = 0;
  process_regulator #(.SAMPLE_CYCLES(SC), .TICKS_PER_S(4)) process_regulator_i (
    .clk(clk), .resetn(resetn), .closedLoop(closedLoop), .setpoint(setpoint),
    .feedback(fb), .proportional_gain_setting(pGain), .integral_time_setting(iTime),
    .derivative_time_setting(dTime), .derivGainLimit(dLim), .feedback_filter_tau(tau),
    .regulator_polarity(pol), .integrator_clamp_enable(clampEn),
    .limitReached(limitReached), .actualFreq(actualFreq), .emergencyMode(mode),
    .emergency_run_frequency(eFreq), .emergency_trip_delay(eDelay),
    .emergPinA(pinA), .emergPinB(pinB), .alarm(alarm), .freqCmd(freqCmd),
    .reverseDir(reverseDir), .emergActive(emergActive), .tripOut(tripOut),
    .tripSuppress(tripSuppress), .bypassOut(bypassOut));
  drive_stage_model drive_stage_model_i (.clk(clk), .resetn(resetn),
    .freqCmd(freqCmd), .actualFreq(actualFreq), .limitReached(limitReached));
  always #2.5 clk = ~clk;
  // ----
  // tasks
  // ----
  task automatic close_out;
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // drives land by nonblocking assignment at the edge; reads see settled values
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wait_high(ref logic s, input int n);
    repeat (n) if (s !== 1'b1) @(posedge clk);
  endtask : wait_high
  task automatic do_reset;
    resetn <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    tick(1);
    `CHK(freqCmd, ZERO_W)
    `CHK(emergActive, 1'b0)
  endtask : do_reset
  task automatic t_off;
    pinA <= 1'b1;
    tick(8);
    `CHK(emergActive, 1'b0)
    pinA <= 1'b0;
  endtask : t_off
  task automatic t_emerg(input logic [1:0] m, input logic useB);
    logic signed [DW-1:0] f;
    mode <= m;
    alarm <= 1'b1;
    if (useB)
      pinB <= 1'b1;
    else
      pinA <= 1'b1;
    wait_high(emergActive, 8);
    `CHK(emergActive, 1'b1)
    `CHK(tripSuppress, 1'b1)
    tick(2);
    f = freqCmd;
    `CHK(reverseDir, m == MODE_REV)
    `CHK(f, {8'h00, eFreq})
    setpoint <= 24'h00_0800;
    tick(3 * SC);
    `CHK(freqCmd, f)
    `CHK(tripOut, 1'b0)
    pinA <= 1'b0;
    pinB <= 1'b0;
    alarm <= 1'b0;
    setpoint <= 24'h00_0100;
    tick(8);
  endtask : t_emerg
  task automatic t_bypass;
    mode <= MODE_BYP;
    pinA <= 1'b1;
    wait_high(emergActive, 8);
    alarm <= 1'b1;
    tick(33);
    `CHK(tripOut, 1'b0)
    `CHK(reverseDir, 1'b0)
    wait_high(tripOut, 40);
    `CHK(tripOut, 1'b1)
    `CHK(bypassOut, 1'b1)
    pinA <= 1'b0;
    alarm <= 1'b0;
    tick(8);
  endtask : t_bypass
  task automatic t_loop(input logic p);
    logic signed [DW-1:0] f1;
    do_reset;
    pol <= p;
    closedLoop <= 1'b1;
    // gain 1.00 on a deviation of 1.0: P is 0x100, I adds P per integral time
    tick(SC);
    `CHK(freqCmd, p ? 24'hFF_FF00 : 24'h00_0100)
    tick(4 * SC);
    `CHK(freqCmd, p ? 24'hFF_FE00 : 24'h00_0200)
    f1 = freqCmd;
    tick(5 * SC);
    `CHK(freqCmd[DW-1], p)
    `CHK(p ? ($signed(freqCmd) < $signed(f1)) : ($signed(freqCmd) > $signed(f1)), 1'b1)
    closedLoop <= 1'b0;
  endtask : t_loop
  initial
  begin
    do_reset;
    t_off;
    t_emerg(MODE_FWD, 1'b0);
    t_emerg(MODE_REV, 1'b1);
    t_bypass;
    t_loop(1'b0);
    t_loop(1'b1);
    close_out;
  end
  initial
  begin
    #100000;
    errors++;
    close_out;
  end
endmodule : test_process_regulator
`default_nettype wire
